// ===== rtl/tdc_addr_step.sv
// Purpose: next address of one side of a transfer after a unit has moved
// Assumes: purely combinational, used once for source and once for destination
// Notes:   a fixed address passes through unchanged

module tdc_addr_step
    import tdc_pkg::*;
(
    input  wire logic [tdc_pkg::TDC_MEM_AW-1:0] i_addr,
    input  wire logic                           i_incr,
    input  wire logic                           i_half,
    output wire logic [tdc_pkg::TDC_MEM_AW-1:0] o_next
);

    wire logic [TDC_MEM_AW-1:0] step;

    // halfword units advance by two, byte units by one
    assign step   = i_half ? TDC_STEP_HALF : TDC_STEP_BYTE;
    assign o_next = i_incr ? (i_addr + step) : i_addr;

endmodule // tdc_addr_step

// ===== rtl/tdc_pkg.sv
// Purpose: shared constants and types of the transfer descriptor controller
// Assumes: one clock, plain register port with 4-bit word index and 16-bit data
// Notes:   per-descriptor registers sit in a stride of four words

package tdc_pkg;

    // sizes
    localparam int TDC_DESC_NUM = 2;                 // descriptor 0 and the last one
    localparam int TDC_DESC_W   = 1;
    localparam int TDC_REG_AW   = 4;
    localparam int TDC_REG_DW   = 16;
    localparam int TDC_MEM_AW   = 16;
    localparam int TDC_MEM_DW   = 16;
    localparam int TDC_CTRL_W   = 8;
    localparam int TDC_BLS_W    = 8;
    localparam int TDC_CNT_W    = 9;                 // block size plus its 256 wrap
    localparam int TDC_FLD_W    = 2;
    localparam int TDC_STAT_W   = 2;

    // register word index: descriptor fields, then the shared registers
    localparam logic [TDC_FLD_W-1:0]  TDC_FLD_CTRL   = 2'h0;
    localparam logic [TDC_FLD_W-1:0]  TDC_FLD_BLS    = 2'h1;
    localparam logic [TDC_FLD_W-1:0]  TDC_FLD_SRC    = 2'h2;
    localparam logic [TDC_FLD_W-1:0]  TDC_FLD_DST    = 2'h3;
    localparam logic [TDC_REG_AW-1:0] TDC_OFS_STATUS = 4'h8;
    localparam logic [TDC_REG_AW-1:0] TDC_OFS_MASK   = 4'h9;
    localparam logic [TDC_REG_AW-1:0] TDC_OFS_ENABLE = 4'hA;

    // control word fields
    localparam int TDC_BIT_MODE   = 0;               // 0 normal, 1 repeat
    localparam int TDC_BIT_AREA   = 1;               // 0 destination, 1 source is repeat area
    localparam int TDC_BIT_SRC    = 2;               // source address mode
    localparam int TDC_BIT_DST    = 3;               // destination address mode
    localparam int TDC_BIT_CHAIN  = 4;
    localparam int TDC_BIT_RIRQ   = 5;               // repeat interrupt enable
    localparam int TDC_BIT_UNIT   = 6;               // 0 byte, 1 halfword
    localparam logic [TDC_CTRL_W-1:0] TDC_CTRL_WMASK = 8'h7F;  // bit 7 reads zero

    // status bits and the busy flag shown beside them
    localparam int TDC_ST_DONE = 0;
    localparam int TDC_ST_RPT  = 1;
    localparam int TDC_BIT_BUSY = 8;

    // reset values
    localparam logic [TDC_CTRL_W-1:0] TDC_CTRL_RST = 8'h00;
    localparam logic [TDC_BLS_W-1:0]  TDC_BLS_RST  = 8'h01;
    localparam logic [TDC_MEM_AW-1:0] TDC_ADDR_RST = 16'h0000;

    // address steps per unit
    localparam logic [TDC_MEM_AW-1:0] TDC_STEP_BYTE = 16'h0001;
    localparam logic [TDC_MEM_AW-1:0] TDC_STEP_HALF = 16'h0002;
    localparam logic [TDC_CNT_W-1:0]  TDC_CNT_ONE   = 9'h001;

    typedef enum logic [2:0] {
        TDC_S_IDLE,
        TDC_S_LOAD,
        TDC_S_READ,
        TDC_S_WRITE,
        TDC_S_END
    } tdc_state_type;

endpackage

// ===== rtl/tdc_top.sv
// Purpose: descriptor-driven transfer engine, byte or halfword units
// Assumes: activation pulses and memory acknowledge are synchronous to i_mclk
// Notes:   one request outstanding on the memory port at a time
//
// Functional notes
// - size field picks byte or halfword units
// - bit 5 enables repeat-cycle completion interrupt
// - repeat interrupt enable ignored in normal mode
// - bit 4 chains to next descriptor
// - bit 3 fixed or incrementing destination
// - destination mode ignored when destination repeats
// - bit 2 fixed or incrementing source
// - source mode ignored when source repeats
// - bit 1 picks destination or source repeat
// - repeat area select ignored in normal mode
// - bit 0 picks normal or repeat mode
// - block size 1..255 units, zero means 256

module tdc_top
    import tdc_pkg::*;
(
    input  wire logic                           i_mclk,
    input  wire logic                           i_reset_n,
    // register port
    input  wire logic [tdc_pkg::TDC_REG_AW-1:0] i_reg_addr,
    input  wire logic [tdc_pkg::TDC_REG_DW-1:0] i_reg_wdata,
    input  wire logic                           i_reg_wr,
    input  wire logic                           i_reg_rd,
    output logic      [tdc_pkg::TDC_REG_DW-1:0] o_reg_rdata,
    // peripheral activation
    input  wire logic                           i_activate,
    input  wire logic [tdc_pkg::TDC_DESC_W-1:0] i_act_desc,
    // memory port
    output logic                                o_mem_req,
    output logic                                o_mem_we,
    output logic                                o_mem_half,
    output logic      [tdc_pkg::TDC_MEM_AW-1:0] o_mem_addr,
    output logic      [tdc_pkg::TDC_MEM_DW-1:0] o_mem_wdata,
    input  wire logic                           i_mem_ack,
    input  wire logic [tdc_pkg::TDC_MEM_DW-1:0] i_mem_rdata,
    // status
    output logic                                o_busy,
    output logic                                o_irq
);

    import tdc_pkg::*;

    // descriptor storage
    logic [TDC_CTRL_W-1:0] desc_ctrl [TDC_DESC_NUM];
    logic [TDC_BLS_W-1:0]  desc_bls  [TDC_DESC_NUM];
    logic [TDC_MEM_AW-1:0] desc_src  [TDC_DESC_NUM];
    logic [TDC_MEM_AW-1:0] desc_dst  [TDC_DESC_NUM];

    // engine state
    tdc_state_type         state;
    tdc_state_type         next_state;
    logic [TDC_DESC_W-1:0] cur_desc;
    logic [TDC_DESC_W-1:0] next_desc;
    logic [TDC_MEM_AW-1:0] cur_src;
    logic [TDC_MEM_AW-1:0] next_src;
    logic [TDC_MEM_AW-1:0] cur_dst;
    logic [TDC_MEM_AW-1:0] next_dst;
    logic [TDC_CNT_W-1:0]  unit_cnt;
    logic [TDC_CNT_W-1:0]  next_cnt;

    // software-visible control and status
    logic [TDC_STAT_W-1:0] irq_status;
    logic [TDC_STAT_W-1:0] irq_mask;
    logic                  engine_enable;
    logic                  act_pending;
    logic [TDC_DESC_W-1:0] act_desc;

    // ------------------------------------------------------------------
    // register port decode
    // ------------------------------------------------------------------
    wire logic                  desc_area;
    wire logic [TDC_DESC_W-1:0] reg_desc;
    wire logic [TDC_FLD_W-1:0]  reg_fld;
    wire logic                  wr_status;
    wire logic                  wr_mask;
    wire logic                  wr_enable;

    // the low word indices hold the descriptors, four fields each
    assign desc_area = (i_reg_addr < TDC_OFS_STATUS);
    assign reg_desc  = i_reg_addr[TDC_FLD_W +: TDC_DESC_W];
    assign reg_fld   = i_reg_addr[TDC_FLD_W-1:0];
    assign wr_status = i_reg_wr && (i_reg_addr == TDC_OFS_STATUS);
    assign wr_mask   = i_reg_wr && (i_reg_addr == TDC_OFS_MASK);
    assign wr_enable = i_reg_wr && (i_reg_addr == TDC_OFS_ENABLE);

    // ------------------------------------------------------------------
    // fields of the running descriptor
    // ------------------------------------------------------------------
    wire logic [TDC_CTRL_W-1:0] cur_ctrl;
    wire logic                  unit_half;
    wire logic                  rpt_mode;
    wire logic                  rpt_src_area;
    wire logic                  rpt_dst_area;
    wire logic                  src_incr;
    wire logic                  dst_incr;
    wire logic                  chain_on;
    wire logic                  rpt_irq_event;
    wire logic                  last_unit;
    wire logic [TDC_CNT_W-1:0]  block_units;

    assign cur_ctrl     = desc_ctrl[cur_desc];
    assign unit_half    = cur_ctrl[TDC_BIT_UNIT];
    assign rpt_mode     = cur_ctrl[TDC_BIT_MODE];
    // area select only counts in repeat mode
    assign rpt_src_area = rpt_mode && cur_ctrl[TDC_BIT_AREA];
    assign rpt_dst_area = rpt_mode && !cur_ctrl[TDC_BIT_AREA];
    // the repeat area always walks its buffer, whatever its mode bit says
    assign src_incr     = cur_ctrl[TDC_BIT_SRC] || rpt_src_area;
    assign dst_incr     = cur_ctrl[TDC_BIT_DST] || rpt_dst_area;
    // the last descriptor never chains, even if its bit were left set
    assign chain_on     = cur_ctrl[TDC_BIT_CHAIN] &&
                          (cur_desc != TDC_DESC_W'(TDC_DESC_NUM - 1));
    assign rpt_irq_event = rpt_mode && cur_ctrl[TDC_BIT_RIRQ];
    assign last_unit    = (unit_cnt == TDC_CNT_ONE);
    // a zero block size stands for 256 units
    assign block_units  = {(desc_bls[cur_desc] == '0), desc_bls[cur_desc]};

    // ------------------------------------------------------------------
    // address steppers
    // ------------------------------------------------------------------
    wire logic [TDC_MEM_AW-1:0] src_stepped;
    wire logic [TDC_MEM_AW-1:0] dst_stepped;

    tdc_addr_step u_src_step (
        .i_addr (cur_src),
        .i_incr (src_incr),
        .i_half (unit_half),
        .o_next (src_stepped)
    );

    tdc_addr_step u_dst_step (
        .i_addr (cur_dst),
        .i_incr (dst_incr),
        .i_half (unit_half),
        .o_next (dst_stepped)
    );

    // ------------------------------------------------------------------
    // sequencer next values
    // ------------------------------------------------------------------
    wire logic start_ok;
    wire logic read_done;
    wire logic write_done;
    wire logic block_end;
    wire logic seq_end;

    assign start_ok   = (state == TDC_S_IDLE) && act_pending && engine_enable;
    assign read_done  = (state == TDC_S_READ) && i_mem_ack;
    assign write_done = (state == TDC_S_WRITE) && i_mem_ack;
    assign block_end  = (state == TDC_S_END);
    assign seq_end    = block_end && !chain_on;

    always_comb begin
        next_state = state;
        next_desc  = cur_desc;
        next_src   = cur_src;
        next_dst   = cur_dst;
        next_cnt   = unit_cnt;
        case (state)
            TDC_S_IDLE: begin
                if (start_ok) begin
                    next_state = TDC_S_LOAD;
                    next_desc  = act_desc;
                end
            end
            TDC_S_LOAD: begin
                next_state = TDC_S_READ;
                next_src   = desc_src[cur_desc];
                next_dst   = desc_dst[cur_desc];
                next_cnt   = block_units;
            end
            TDC_S_READ: begin
                if (i_mem_ack) begin
                    next_state = TDC_S_WRITE;
                    next_src   = src_stepped;
                end
            end
            TDC_S_WRITE: begin
                if (i_mem_ack) begin
                    next_dst = dst_stepped;
                    next_cnt = unit_cnt - TDC_CNT_ONE;
                    next_state = last_unit ? TDC_S_END : TDC_S_READ;
                end
            end
            TDC_S_END: begin
                if (chain_on) begin
                    next_state = TDC_S_LOAD;
                    next_desc  = cur_desc + TDC_DESC_W'(1);
                end else begin
                    next_state = TDC_S_IDLE;
                end
            end
            default: begin
                next_state = TDC_S_IDLE;
            end
        endcase
    end

    // sequencer registers
    always_ff @(posedge i_mclk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            state    <= TDC_S_IDLE;
            cur_desc <= '0;
            cur_src  <= TDC_ADDR_RST;
            cur_dst  <= TDC_ADDR_RST;
            unit_cnt <= '0;
        end else begin
            state    <= next_state;
            cur_desc <= next_desc;
            cur_src  <= next_src;
            cur_dst  <= next_dst;
            unit_cnt <= next_cnt;
        end
    end

    // ------------------------------------------------------------------
    // memory port, registered from the next values
    // ------------------------------------------------------------------
    wire logic                  next_req;
    wire logic                  next_we;
    wire logic [TDC_MEM_AW-1:0] next_mem_addr;
    wire logic                  next_half;

    assign next_req      = (next_state == TDC_S_READ) || (next_state == TDC_S_WRITE);
    assign next_we       = (next_state == TDC_S_WRITE);
    assign next_mem_addr = next_we ? next_dst : next_src;
    assign next_half     = desc_ctrl[next_desc][TDC_BIT_UNIT];

    always_ff @(posedge i_mclk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_mem_req  <= 1'b0;
            o_mem_we   <= 1'b0;
            o_mem_half <= 1'b0;
            o_mem_addr <= TDC_ADDR_RST;
        end else begin
            o_mem_req  <= next_req;
            o_mem_we   <= next_we;
            o_mem_half <= next_half;
            o_mem_addr <= next_mem_addr;
        end
    end

    // read data held for the write; byte units use only the low byte
    always_ff @(posedge i_mclk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_mem_wdata <= '0;
        end else if (read_done) begin
            o_mem_wdata <= unit_half ? i_mem_rdata :
                           {8'h00, i_mem_rdata[7:0]};
        end
    end

    // ------------------------------------------------------------------
    // descriptor registers: block-end write-back beats a software write
    // ------------------------------------------------------------------
    genvar g;
    generate
        for (g = 0; g < TDC_DESC_NUM; g++) begin : g_desc
            wire logic own_wb;
            wire logic sw_wr;

            assign own_wb = block_end && (cur_desc == TDC_DESC_W'(g));
            assign sw_wr  = i_reg_wr && desc_area && (reg_desc == TDC_DESC_W'(g));

            always_ff @(posedge i_mclk or negedge i_reset_n) begin
                if (!i_reset_n) begin
                    desc_ctrl[g] <= TDC_CTRL_RST;
                    desc_bls[g]  <= TDC_BLS_RST;
                    desc_src[g]  <= TDC_ADDR_RST;
                    desc_dst[g]  <= TDC_ADDR_RST;
                end else if (own_wb) begin
                    // the repeat area returns to its start, the other side moves on
                    if (!rpt_src_area) begin
                        desc_src[g] <= cur_src;
                    end
                    if (!rpt_dst_area) begin
                        desc_dst[g] <= cur_dst;
                    end
                end else if (sw_wr) begin
                    case (reg_fld)
                        TDC_FLD_CTRL: desc_ctrl[g] <= i_reg_wdata[TDC_CTRL_W-1:0] &
                                                      TDC_CTRL_WMASK;
                        TDC_FLD_BLS:  desc_bls[g]  <= i_reg_wdata[TDC_BLS_W-1:0];
                        TDC_FLD_SRC:  desc_src[g]  <= i_reg_wdata;
                        TDC_FLD_DST:  desc_dst[g]  <= i_reg_wdata;
                        default:      desc_bls[g]  <= desc_bls[g];
                    endcase
                end
            end
        end
    endgenerate

    // ------------------------------------------------------------------
    // activation request: held until the idle engine takes it
    // ------------------------------------------------------------------
    always_ff @(posedge i_mclk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            act_pending <= 1'b0;
            act_desc    <= '0;
        end else if (i_activate) begin
            act_pending <= 1'b1;                  // a new event beats the take
            act_desc    <= i_act_desc;
        end else if (start_ok) begin
            act_pending <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // interrupt status, mask and enable
    // ------------------------------------------------------------------
    wire logic [TDC_STAT_W-1:0] stat_set;
    wire logic [TDC_STAT_W-1:0] stat_clr;
    wire logic [TDC_STAT_W-1:0] next_status;
    wire logic [TDC_STAT_W-1:0] next_mask;

    assign stat_set[TDC_ST_DONE] = seq_end;
    assign stat_set[TDC_ST_RPT]  = block_end && rpt_irq_event;
    assign stat_clr    = wr_status ? i_reg_wdata[TDC_STAT_W-1:0] : '0;
    // a set in the clearing cycle survives
    assign next_status = (irq_status & ~stat_clr) | stat_set;
    assign next_mask   = wr_mask ? i_reg_wdata[TDC_STAT_W-1:0] : irq_mask;

    always_ff @(posedge i_mclk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            irq_status <= '0;
            o_irq      <= 1'b0;
        end else begin
            irq_status <= next_status;
            o_irq      <= |(next_status & next_mask);
        end
    end

    always_ff @(posedge i_mclk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            irq_mask      <= '0;
            engine_enable <= 1'b0;
        end else begin
            irq_mask <= next_mask;
            if (wr_enable) begin
                engine_enable <= i_reg_wdata[0];
            end
        end
    end

    // busy covers everything from the take to the return to idle
    always_ff @(posedge i_mclk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_busy <= 1'b0;
        end else begin
            o_busy <= (next_state != TDC_S_IDLE);
        end
    end

    // ------------------------------------------------------------------
    // read-back: data stand for exactly one cycle after the strobe
    // ------------------------------------------------------------------
    logic [TDC_REG_DW-1:0] rd_mux;

    always_comb begin
        rd_mux = '0;
        if (desc_area) begin
            case (reg_fld)
                TDC_FLD_CTRL: rd_mux = {8'h00, desc_ctrl[reg_desc]};
                TDC_FLD_BLS:  rd_mux = {8'h00, desc_bls[reg_desc]};
                TDC_FLD_SRC:  rd_mux = desc_src[reg_desc];
                TDC_FLD_DST:  rd_mux = desc_dst[reg_desc];
                default:      rd_mux = '0;
            endcase
        end else if (i_reg_addr == TDC_OFS_STATUS) begin
            rd_mux[TDC_STAT_W-1:0] = irq_status;
            rd_mux[TDC_BIT_BUSY]   = o_busy;
        end else if (i_reg_addr == TDC_OFS_MASK) begin
            rd_mux[TDC_STAT_W-1:0] = irq_mask;
        end else if (i_reg_addr == TDC_OFS_ENABLE) begin
            rd_mux[0] = engine_enable;
        end
    end

    always_ff @(posedge i_mclk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_reg_rdata <= '0;
        end else begin
            o_reg_rdata <= i_reg_rd ? rd_mux : '0;   // unmapped words read zero
        end
    end

endmodule // tdc_top

// ===== tb/tb_tdc_top.sv
// Purpose: register-driven transfer scenarios of the descriptor engine
// Assumes: one descriptor pair, memory model answers fast or slow
// Notes:   expected addresses and data derive from the control word and block size
module tb_tdc_top;
    timeunit 1ns;
    timeprecision 1ps;
    import tdc_pkg::*;

    logic        mclk = 1'b0, reset_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
    logic        act = 1'b0, adesc = 1'b0, slow = 1'b0, irq_s, lw_half;
    logic [3:0]  reg_addr = 4'h0;
    logic [15:0] reg_wdata = 16'h0000, lw_addr, lw_data;
    wire  logic [15:0] reg_rdata, mem_addr, mem_wdata, mem_rdata;
    wire  logic        mem_req, mem_we, mem_half, mem_ack, busy, irq;
    int          error_cnt = 0, n_tests = 0, wcnt = 0, wb;
    logic [7:0]  t_ctl [6] = '{8'h04, 8'h4C, 8'h21, 8'h03, 8'h26, 8'h48};
    logic [7:0]  t_bls [6] = '{8'h03, 8'h02, 8'h03, 8'h02, 8'h02, 8'h00};

    always #4 mclk = ~mclk;

    tdc_top u_dut (.i_mclk(mclk), .i_reset_n(reset_n), .i_reg_addr(reg_addr),
        .i_reg_wdata(reg_wdata), .i_reg_wr(reg_wr), .i_reg_rd(reg_rd), .o_reg_rdata(reg_rdata),
        .i_activate(act), .i_act_desc(adesc), .o_mem_req(mem_req), .o_mem_we(mem_we),
        .o_mem_half(mem_half), .o_mem_addr(mem_addr), .o_mem_wdata(mem_wdata),
        .i_mem_ack(mem_ack), .i_mem_rdata(mem_rdata), .o_busy(busy), .o_irq(irq));
    tdc_mem_model u_mem (.i_mclk(mclk), .i_reset_n(reset_n), .i_req(mem_req),
        .i_addr(mem_addr), .i_slow(slow), .o_ack(mem_ack), .o_rdata(mem_rdata));

    // keep the last written unit; counting writes shows the block length
    always @(posedge mclk) begin
        if (mem_req && mem_ack && mem_we) begin
            wcnt <= wcnt + 1;
            lw_addr <= mem_addr;
            lw_data <= mem_wdata;
            lw_half <= mem_half;
        end
    end

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_tests++;
        if (got !== exp) begin
            error_cnt++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge mclk);
        reg_wr <= 1'b0;
        @(posedge mclk);
    endtask

    // read data stands only in the cycle after the strobe
    task automatic rchk(input logic [3:0] a, input logic [15:0] m, input logic [15:0] e);
        logic [15:0] d;
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge mclk);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
        irq_s = irq;
        chk(d & m, e);
        @(posedge mclk);
    endtask

    task automatic kick_and_wait();
        int k;
        k = 0;
        act <= 1'b1;
        @(posedge mclk);
        act <= 1'b0;
        while (busy !== 1'b1 && k < 20) begin
            #1 k++;
            @(posedge mclk);
        end
        while (busy === 1'b1) @(posedge mclk);
        @(posedge mclk);
    endtask

    task automatic results();
        $display("comparisons %0d, mismatches %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // run one descriptor-0 block and check traffic, write-back and status
    task automatic run(input logic [7:0] c, input logic [7:0] b, input logic sl);
        logic [15:0] s, t, lr;
        int n, sp;
        logic asrc, adst;
        s = 16'h1230;
        t = 16'h4560;
        n = (b == 8'h00) ? 256 : b;
        sp = c[6] ? 2 : 1;
        asrc = c[0] & c[1];
        adst = c[0] & !c[1];
        lr = s + 16'((n - 1) * sp * (c[2] | asrc));
        slow <= sl;
        wr(4'h0, {8'h00, c});
        wr(4'h1, {8'h00, b});
        wr(4'h2, s);
        wr(4'h3, t);
        wb = wcnt;
        kick_and_wait();
        chk(16'(wcnt - wb), 16'(n));
        chk(lw_data, c[6] ? ~lr : {8'h00, ~lr[7:0]});
        chk({15'h0, lw_half}, {15'h0, c[6]});
        chk(lw_addr, t + 16'((n - 1) * sp * (c[3] | adst)));
        rchk(4'h2, 16'hFFFF, asrc ? s : s + 16'(n * sp * c[2]));
        rchk(4'h3, 16'hFFFF, adst ? t : t + 16'(n * sp * c[3]));
        rchk(4'h8, 16'h0003, {14'h0, c[0] & c[5], 1'b1});
        chk({15'h0, irq_s}, {15'h0, c[0] & c[5]});
        wr(4'h8, 16'h0003);
    endtask

    // watchdog: all scenarios need well under this many cycles
    initial begin
        repeat (20000) @(posedge mclk);
        error_cnt++;
        results();
    end

    initial begin
        repeat (16) @(posedge mclk);
        reset_n <= 1'b1;
        @(posedge mclk);
        rchk(4'h0, 16'hFFFF, 16'h0000);
        rchk(4'h1, 16'hFFFF, 16'h0001);
        wr(4'h0, 16'h00FF);
        rchk(4'h0, 16'hFFFF, 16'h007F);
        wr(4'hB, 16'hFFFF);
        rchk(4'hB, 16'hFFFF, 16'h0000);
        $display("test registers done");
        wr(4'h4, 16'h0000);
        wr(4'h5, 16'h0002);
        wr(4'h0, 16'h0010);
        wr(4'h1, 16'h0001);
        wb = wcnt;
        act <= 1'b1;
        @(posedge mclk);
        act <= 1'b0;
        repeat (8) @(posedge mclk);
        rchk(4'h8, 16'h0100, 16'h0000);
        wr(4'hA, 16'h0001);
        while (busy !== 1'b1) @(posedge mclk);
        while (busy === 1'b1) @(posedge mclk);
        chk(16'(wcnt - wb), 16'h0003);
        wr(4'h8, 16'h0003);
        wr(4'h9, 16'h0002);
        $display("test chain done");
        for (int i = 0; i < 6; i++) begin
            run(t_ctl[i], t_bls[i], i[0]);
            $display("test block %0d done", i);
        end
        results();
    end
endmodule // tb_tdc_top

// ===== tb/tdc_mem_model.sv
// Purpose: memory seen from the engine's memory port
// Assumes: read data is the inverted address, so every unit is traceable
// Notes:   slow mode waits four cycles per request
module tdc_mem_model (
    input  wire logic        i_mclk,
    input  wire logic        i_reset_n,
    input  wire logic        i_req,
    input  wire logic [15:0] i_addr,
    input  wire logic        i_slow,
    output logic             o_ack,
    output logic      [15:0] o_rdata
);
    logic [1:0] wait_cnt;

    // one ack pulse per request, never two in a row
    always_ff @(posedge i_mclk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_ack <= 1'b0;
            wait_cnt <= 2'h0;
        end else begin
            o_ack <= i_req && !o_ack && (!i_slow || wait_cnt == 2'h3);
            wait_cnt <= (i_req && !o_ack) ? wait_cnt + 2'h1 : 2'h0;
        end
    end

    // outside the ack the bus shows a different value, so stale data cannot pass
    assign o_rdata = o_ack ? ~i_addr : i_addr;
endmodule // tdc_mem_model

// ===== tb/tdc_top_props.sv
// Purpose: port-level checks of the transfer descriptor engine
// Assumes: sees only the top ports, one clock domain
// Notes:   register contents are judged by the bench, not here
module tdc_top_props
    import tdc_pkg::*;
(
    input wire logic                           i_mclk,
    input wire logic                           i_reset_n,
    input wire logic [tdc_pkg::TDC_REG_AW-1:0] i_reg_addr,
    input wire logic [tdc_pkg::TDC_REG_DW-1:0] i_reg_wdata,
    input wire logic                           i_reg_wr,
    input wire logic                           i_reg_rd,
    input wire logic [tdc_pkg::TDC_REG_DW-1:0] o_reg_rdata,
    input wire logic                           i_activate,
    input wire logic [tdc_pkg::TDC_DESC_W-1:0] i_act_desc,
    input wire logic                           o_mem_req,
    input wire logic                           o_mem_we,
    input wire logic                           o_mem_half,
    input wire logic [tdc_pkg::TDC_MEM_AW-1:0] o_mem_addr,
    input wire logic [tdc_pkg::TDC_MEM_DW-1:0] o_mem_wdata,
    input wire logic                           i_mem_ack,
    input wire logic [tdc_pkg::TDC_MEM_DW-1:0] i_mem_rdata,
    input wire logic                           o_busy,
    input wire logic                           o_irq
);
    default clocking @(posedge i_mclk); endclocking
    default disable iff (!i_reset_n);

    a_req_held: assert property (o_mem_req && !i_mem_ack |=> o_mem_req
        && $stable(o_mem_addr) && $stable(o_mem_we)) else $error("request changed before ack");
    a_write_follows: assert property (o_mem_req && i_mem_ack && !o_mem_we |=> o_mem_req
        && o_mem_we) else $error("no write right after read ack");
    a_unit_kept: assert property (
        o_mem_req && i_mem_ack && !o_mem_we |=> o_mem_half == $past(o_mem_half))
        else $error("unit size changed within a unit");
    a_byte_upper: assert property (
        o_mem_req && o_mem_we && !o_mem_half |-> o_mem_wdata[15:8] == 8'h00)
        else $error("byte write carries upper byte");
    a_req_busy: assert property (o_mem_req |-> o_busy) else $error("request while idle");
    a_start_read: assert property ($rose(o_busy) |=> o_mem_req && !o_mem_we)
        else $error("sequence did not open with a read");
    a_rdata_quiet: assert property (!$past(i_reg_rd) |-> o_reg_rdata == 16'h0000)
        else $error("read data outside its cycle");
    a_irq_cause: assert property ($rose(o_irq) |-> $past(o_busy) || $past(i_reg_wr)
        || $past(i_reg_wr, 2)) else $error("interrupt rose without cause");
endmodule // tdc_top_props

bind tdc_top tdc_top_props u_props (
    .i_mclk(i_mclk), .i_reset_n(i_reset_n), .i_reg_addr(i_reg_addr),
    .i_reg_wdata(i_reg_wdata), .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd),
    .o_reg_rdata(o_reg_rdata), .i_activate(i_activate), .i_act_desc(i_act_desc),
    .o_mem_req(o_mem_req), .o_mem_we(o_mem_we), .o_mem_half(o_mem_half),
    .o_mem_addr(o_mem_addr), .o_mem_wdata(o_mem_wdata), .i_mem_ack(i_mem_ack),
    .i_mem_rdata(i_mem_rdata), .o_busy(o_busy), .o_irq(o_irq));
